/* rtl/exec_cycle_timer.sv */
// down-counter that holds fetch off for the added cycles of an instruction
`timescale 1ns/1ps
module exec_cycle_timer #(
  parameter int CNT_W = 2
) (
  input  wire logic             mclk_i,
  input  wire logic             sys_rst_i,
  input  wire logic             clk_en_i,
  input  wire logic             load_i,
  input  wire logic [CNT_W-1:0] count_i,
  output logic                  busy_o
);

  logic [CNT_W-1:0] remain;

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      remain <= '0;
    end else if (clk_en_i) begin
      if (load_i) begin
        remain <= count_i;
      end else if (remain != '0) begin
        remain <= remain - CNT_W'(1);
      end
    end
  end

  assign busy_o = (remain != '0);

endmodule : exec_cycle_timer

/* rtl/instruction_word_decoder.sv */
// instruction word decoder: classifies, extracts operands, pairs words, times execution
// How it works
// - one word: 24 bits, 8-bit opcode on top
// - only three opcodes take two words
// - pair decoded from both words, 48 bits
// - second word upper byte must be zero
// - lone second word executes as nop
// - plain single word takes one cycle
// - true condition or pc change: two cycles
// - branches, tables, returns take two or three
// - taken skip: two or three cycles by length
// - double-word moves take two cycles
// - two-word instructions take two cycles
// - five groups: word/byte, bit, literal, dsp, control
// - base plain, source and destination with modifiers
// - file form: address plus file-or-w0 destination
// - bit number literal or from base register
// - literal math: base, literal, optional destination
// - multiply-accumulate: accumulator, operands, prefetch, write-back
// - other dsp: accumulator, shift by register or literal
// - register fields select one of sixteen
`include "instruction_word_decoder_cfg.svh"
`timescale 1ns/1ps
module instruction_word_decoder
  import instruction_word_decoder_pkg::*;
(
  input  wire logic                  mclk_i,
  input  wire logic                  sys_rst_i,
  input  wire logic                  clk_en_i,
  input  wire logic                  fetch_valid_i,
  input  wire logic [`IWD_WORD_W-1:0] fetch_word_i,
  input  wire logic                  cond_true_i,
  input  wire logic                  pc_write_i,
  output logic                       fetch_ready_o,
  output logic                       issue_o,
  output decoded_s                   decoded_o,
  output logic [1:0]                 exec_cycles_o,
  output logic                       nop_cycle_o,
  output logic                       second_word_next_o,
  output logic                       pair_error_o
);

  typedef enum logic [1:0] {
    ST_FETCH,
    ST_SECOND,
    ST_SKIP,
    ST_SKIP_SECOND
  } state_e;

  state_e                  state;
  state_e                  next_state;
  logic                    accept;
  logic                    timer_busy;
  logic                    flush_nop;
  logic [7:0]              fetch_op;
  logic [`IWD_WORD_W-1:0]  pair_first;
  logic                    single_issue;
  logic                    pair_issue;
  logic [1:0]              single_cycles;
  logic                    timer_load;
  logic [1:0]              timer_count;
  logic                    upper_zero;

  function automatic logic is_two_word(input logic [7:0] op);
    return (op == `IWD_OP_CALL_LONG) || (op == `IWD_OP_GOTO_LONG) ||
           (op == `IWD_OP_LOOP_LONG);
  endfunction : is_two_word

  function automatic category_e classify(input logic [7:0] op);
    category_e c;
    c = CAT_CONTROL;
    unique case (op[`IWD_OPC_GRP])
      `IWD_GRP_LIT:                 c = CAT_LITERAL;
      `IWD_GRP_WB_LO, `IWD_GRP_WB_HI: c = CAT_WORD_BYTE;
      `IWD_GRP_BIT:                 c = CAT_BIT;
      `IWD_GRP_MULACC, `IWD_GRP_DSP: c = CAT_DSP;
      default:                      c = CAT_CONTROL;
    endcase
    return c;
  endfunction : classify

  function automatic logic [1:0] base_cycles(input logic [7:0] op);
    logic [1:0] n;
    n = `IWD_CYC_ONE;
    unique case (op)
      `IWD_OP_RETURN, `IWD_OP_RETINT: n = `IWD_CYC_THREE;
      `IWD_OP_BRANCH_ALWAYS, `IWD_OP_CALL_IND, `IWD_OP_GOTO_IND,
      `IWD_OP_TBL_RD, `IWD_OP_TBL_WR: n = `IWD_CYC_TWO;
      `IWD_OP_MOVE_DBL:               n = `IWD_CYC_TWO;
      default:                        n = `IWD_CYC_ONE;
    endcase
    return n;
  endfunction : base_cycles

  // register fields are four bits wide, so any of w0..w15 is reachable
  function automatic decoded_s decode_word(input logic [`IWD_WORD_W-1:0] w);
    decoded_s   d;
    logic [7:0] op;
    d = '0;
    op = w[`IWD_OPC];
    d.opcode = op;
    d.category = classify(op);
    d.is_nop = (op == `IWD_OP_NOP);
    d.byte_mode = op[`IWD_OP_BYTE];
    unique case (d.category)
      CAT_WORD_BYTE: begin
        if (op[`IWD_OP_SUBSEL]) begin
          d.file_form = 1'b1;
          d.file_addr = w[`IWD_F_FILE];
          d.file_to_file = w[`IWD_F_FILE_SEL];
        end else begin
          d.base_reg_operand = w[`IWD_F_BASE];
          d.source_reg_operand = w[`IWD_F_SRC];
          d.src_mode = w[`IWD_F_SMODE];
          d.dest_reg_operand = w[`IWD_F_DST];
          d.dst_mode = w[`IWD_F_DMODE];
        end
      end
      CAT_BIT: begin
        d.source_reg_operand = w[`IWD_F_SRC];
        d.src_mode = w[`IWD_F_SMODE];
        d.bit_indirect = w[`IWD_F_BIT_IND];
        d.bit_num = w[`IWD_F_BASE];
        d.base_reg_operand = w[`IWD_F_BASE];
      end
      CAT_LITERAL: begin
        if (op[`IWD_OP_SUBSEL]) begin
          d.literal = {4'h0, w[`IWD_F_LITMOV]};
          d.dest_reg_operand = w[`IWD_F_SRC];
        end else begin
          d.base_reg_operand = w[`IWD_F_BASE];
          d.literal = {11'h000, w[`IWD_F_LIT5]};
          if (w[`IWD_F_LDST_PRES]) begin
            d.dest_reg_operand = w[`IWD_F_LDST];
            d.dst_mode = w[`IWD_F_LDST_MODE];
          end else begin
            d.dest_reg_operand = w[`IWD_F_BASE];
          end
        end
      end
      CAT_DSP: begin
        d.acc_b = w[`IWD_F_ACC];
        if (op[`IWD_OPC_GRP] == `IWD_GRP_MULACC) begin
          d.multiply_accumulate = 1'b1;
          d.wx = w[`IWD_F_WX];
          d.wy = w[`IWD_F_WY];
          d.x_op = w[`IWD_F_XOP];
          d.y_op = w[`IWD_F_YOP];
          d.x_dst = w[`IWD_F_XD];
          d.y_dst = w[`IWD_F_YD];
          d.awb = w[`IWD_F_AWB];
        end else begin
          d.shift_from_reg = w[`IWD_F_SH_REG];
          d.source_reg_operand = w[`IWD_F_SRC];
          d.shift_amt = w[`IWD_F_SH_LIT];
          d.dest_reg_operand = w[`IWD_F_SH_DST];
        end
      end
      CAT_CONTROL: begin
        d.target = {7'h00, w[`IWD_F_TGT_LO]};
      end
    endcase
    return d;
  endfunction : decode_word

  assign fetch_op = fetch_word_i[`IWD_OPC];
  assign fetch_ready_o = !timer_busy;
  assign accept = clk_en_i && fetch_valid_i && fetch_ready_o;
  assign upper_zero = (fetch_op == 8'h00);
  assign single_issue = accept && (state == ST_FETCH) && !is_two_word(fetch_op);
  assign pair_issue = accept && (state == ST_SECOND);
  assign nop_cycle_o = timer_busy || flush_nop;

  always_comb begin
    single_cycles = base_cycles(fetch_op);
    if (fetch_op == `IWD_OP_SKIP) begin
      single_cycles = `IWD_CYC_ONE; // skipped words show up as flushed nops
    end else if (!upper_zero && single_cycles == `IWD_CYC_ONE &&
                 (pc_write_i || (fetch_op == `IWD_OP_BRANCH_CND && cond_true_i))) begin
      single_cycles = `IWD_CYC_TWO;
    end
    timer_load = single_issue && (single_cycles != `IWD_CYC_ONE);
    timer_count = single_cycles - `IWD_CYC_ONE;
  end

  always_comb begin
    next_state = state;
    if (accept) begin
      unique case (state)
        ST_FETCH: begin
          if (is_two_word(fetch_op)) begin
            next_state = ST_SECOND;
          end else if (fetch_op == `IWD_OP_SKIP && cond_true_i) begin
            next_state = ST_SKIP;
          end
        end
        ST_SKIP: begin
          next_state = is_two_word(fetch_op) ? ST_SKIP_SECOND : ST_FETCH;
        end
        ST_SECOND, ST_SKIP_SECOND: begin
          next_state = ST_FETCH;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state <= ST_FETCH;
      second_word_next_o <= 1'b0;
    end else if (clk_en_i) begin
      state <= next_state;
      second_word_next_o <= (next_state == ST_SECOND) ||
                            (next_state == ST_SKIP_SECOND);
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pair_first <= '0;
    end else if (accept && state == ST_FETCH && is_two_word(fetch_op)) begin
      pair_first <= fetch_word_i;
    end
  end

  // skipped words are fetched and thrown away, one nop cycle each
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      flush_nop <= 1'b0;
    end else if (clk_en_i) begin
      flush_nop <= accept && (state == ST_SKIP || state == ST_SKIP_SECOND);
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      issue_o <= 1'b0;
      decoded_o <= '0;
      exec_cycles_o <= `IWD_CYC_ONE;
      pair_error_o <= 1'b0;
    end else if (clk_en_i) begin
      issue_o <= single_issue || pair_issue;
      pair_error_o <= pair_issue && !upper_zero;
      if (single_issue) begin
        decoded_o <= decode_word(fetch_word_i);
        exec_cycles_o <= single_cycles;
      end else if (pair_issue) begin
        decoded_o <= decode_word(pair_first);
        decoded_o.two_word <= 1'b1;
        decoded_o.target <= {fetch_word_i[`IWD_F_TGT_HI], pair_first[`IWD_F_TGT_LO]};
        decoded_o.literal <= fetch_word_i[`IWD_F_TGT_LO];
        decoded_o.is_nop <= !upper_zero; // a malformed pair does nothing
        exec_cycles_o <= `IWD_CYC_TWO;
      end
    end
  end

  exec_cycle_timer #(
    .CNT_W (2)
  ) u_timer (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .clk_en_i  (clk_en_i),
    .load_i    (timer_load),
    .count_i   (timer_count),
    .busy_o    (timer_busy)
  );

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i || !clk_en_i);

  sequence s_stall_one;
    nop_cycle_o && !fetch_ready_o ##1 fetch_ready_o;
  endsequence

  sequence s_stall_two;
    !fetch_ready_o [*2] ##1 fetch_ready_o;
  endsequence

  a_single_ready: assert property (
    issue_o && exec_cycles_o == `IWD_CYC_ONE |-> fetch_ready_o)
    else $error("one-cycle instruction stalled fetch");

  a_extra_nop: assert property (
    issue_o && exec_cycles_o == `IWD_CYC_TWO && !decoded_o.two_word |-> s_stall_one)
    else $error("two-cycle single word did not add exactly one nop cycle");

  a_three_cycle: assert property (
    issue_o && exec_cycles_o == `IWD_CYC_THREE |-> s_stall_two)
    else $error("three-cycle instruction did not stall two cycles");

  a_pair_two: assert property (
    issue_o && decoded_o.two_word |-> exec_cycles_o == `IWD_CYC_TWO && fetch_ready_o)
    else $error("two-word instruction not timed at two cycles");

  a_lone_second: assert property (
    accept && state == ST_FETCH && upper_zero
    |=> issue_o && decoded_o.is_nop && exec_cycles_o == `IWD_CYC_ONE)
    else $error("lone second word did not issue as a one-cycle nop");

  a_pair_flag: assert property (
    accept && state == ST_FETCH && is_two_word(fetch_op) |=> second_word_next_o && !issue_o)
    else $error("pair first word did not mark the next word");

  a_skip_chain: assert property (
    accept && state == ST_SKIP && is_two_word(fetch_op)
    |=> second_word_next_o && nop_cycle_o && !issue_o)
    else $error("skipped two-word instruction not flushed whole");

  a_pair_reject: assert property (
    accept && state == ST_SECOND && !upper_zero |=> pair_error_o && issue_o && decoded_o.is_nop)
    else $error("second word with nonzero upper byte was accepted");

  // skipped words are still fetched so that pair tracking stays in step,
  // but none of them may reach the datapath
  sequence s_flushed;
    nop_cycle_o && !issue_o;
  endsequence

  a_skip_flush: assert property (
    accept && (state == ST_SKIP || state == ST_SKIP_SECOND) |=> s_flushed)
    else $error("skipped word was issued instead of flushed");

  a_skip_single: assert property (
    accept && state == ST_SKIP && !is_two_word(fetch_op) |=> !second_word_next_o)
    else $error("skipped one-word instruction left a second word pending");

  a_double_move: assert property (
    issue_o && decoded_o.opcode == `IWD_OP_MOVE_DBL |-> exec_cycles_o == `IWD_CYC_TWO)
    else $error("double-word move not timed at two cycles");

  a_pc_write: assert property (
    single_issue && !upper_zero && fetch_op != `IWD_OP_SKIP && pc_write_i
    |=> exec_cycles_o != `IWD_CYC_ONE)
    else $error("program counter write did not add a cycle");

  a_pair_done: assert property (
    issue_o && decoded_o.two_word |-> !second_word_next_o)
    else $error("pair issued while a second word was still expected");

  // a stalled instruction owns its nop cycles; nothing else may issue in them
  a_stall_quiet: assert property (
    issue_o && exec_cycles_o != `IWD_CYC_ONE && !decoded_o.two_word |=> !issue_o)
    else $error("issue seen inside the nop cycle of a stalled instruction");

endmodule : instruction_word_decoder

/* rtl/instruction_word_decoder_cfg.svh */
// encodings, field positions and cycle counts of the instruction word decoder
`ifndef INSTRUCTION_WORD_DECODER_CFG_SVH
`define INSTRUCTION_WORD_DECODER_CFG_SVH

`define IWD_WORD_W        24
`define IWD_OPC           23:16
`define IWD_OPC_GRP       7:5
`define IWD_OP_SUBSEL     4
`define IWD_OP_BYTE       0

`define IWD_GRP_CTRL      3'h0
`define IWD_GRP_LIT       3'h1
`define IWD_GRP_WB_LO     3'h2
`define IWD_GRP_WB_HI     3'h3
`define IWD_GRP_BIT       3'h4
`define IWD_GRP_MULACC    3'h5
`define IWD_GRP_DSP       3'h6

`define IWD_OP_NOP        8'h00
`define IWD_OP_CALL_IND   8'h01
`define IWD_OP_CALL_LONG  8'h02
`define IWD_OP_GOTO_IND   8'h03
`define IWD_OP_GOTO_LONG  8'h04
`define IWD_OP_BRANCH_ALWAYS 8'h05
`define IWD_OP_RETURN     8'h06
`define IWD_OP_RETINT     8'h07
`define IWD_OP_LOOP_LONG  8'h08
`define IWD_OP_BRANCH_CND 8'h09
`define IWD_OP_SKIP       8'h0A
`define IWD_OP_TBL_RD     8'h0B
`define IWD_OP_TBL_WR     8'h0C
`define IWD_OP_MOVE_DBL   8'h5F

`define IWD_F_BASE        15:12
`define IWD_F_DMODE       11:10
`define IWD_F_DST         9:6
`define IWD_F_SMODE       5:4
`define IWD_F_SRC         3:0
`define IWD_F_FILE_SEL    13
`define IWD_F_FILE        12:0
`define IWD_F_BIT_IND     11
`define IWD_F_LDST_PRES   11
`define IWD_F_LDST        10:7
`define IWD_F_LDST_MODE   6:5
`define IWD_F_LIT5        4:0
`define IWD_F_LITMOV      15:4
`define IWD_F_ACC         15
`define IWD_F_WX          14:13
`define IWD_F_WY          12:11
`define IWD_F_XOP         10:8
`define IWD_F_YOP         7:5
`define IWD_F_XD          4:3
`define IWD_F_YD          2:1
`define IWD_F_AWB         0
`define IWD_F_SH_REG      14
`define IWD_F_SH_DST      13:10
`define IWD_F_SH_LIT      9:4
`define IWD_F_TGT_LO      15:0
`define IWD_F_TGT_HI      6:0

`define IWD_CYC_ONE       2'h1
`define IWD_CYC_TWO       2'h2
`define IWD_CYC_THREE     2'h3

`endif

/* rtl/instruction_word_decoder_pkg.sv */
// types shared by the instruction word decoder
package instruction_word_decoder_pkg;

  typedef logic [3:0] default_working_register_t;

  typedef enum logic [2:0] {
    CAT_WORD_BYTE,
    CAT_BIT,
    CAT_LITERAL,
    CAT_DSP,
    CAT_CONTROL
  } category_e;

  typedef struct packed {
    logic [7:0]  opcode;
    category_e   category;
    logic        is_nop;
    logic        two_word;
    logic        byte_mode;
    logic        file_form;
    logic        file_to_file;
    default_working_register_t       base_reg_operand;
    default_working_register_t       source_reg_operand;
    logic [1:0]  src_mode;
    default_working_register_t       dest_reg_operand;
    logic [1:0]  dst_mode;
    logic [12:0] file_addr;
    logic [3:0]  bit_num;
    logic        bit_indirect;
    logic [15:0] literal;
    logic        multiply_accumulate;
    logic        acc_b;
    logic [1:0]  wx;
    logic [1:0]  wy;
    logic [2:0]  x_op;
    logic [2:0]  y_op;
    logic [1:0]  x_dst;
    logic [1:0]  y_dst;
    logic        awb;
    logic        shift_from_reg;
    logic [5:0]  shift_amt;
    logic [22:0] target;
  } decoded_s;

endpackage : instruction_word_decoder_pkg

/* sim/instruction_word_decoder_tb.sv */
// self-checking testbench of the instruction word decoder
`include "instruction_word_decoder_cfg.svh"
`timescale 1ns/1ps
module instruction_word_decoder_tb
  import instruction_word_decoder_pkg::*;
;
  typedef struct packed {
    decoded_s   d;
    logic [1:0] cyc;
    logic       perr;
  } issue_rec_s;
  logic        mclk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        en = 1'b1;
  logic        go = 1'b0;
  logic        gap = 1'b0;
  logic [4:0]  plen = 5'h00;
  logic [25:0] prog [16];
  logic        fvalid, fready, cond, pcw, mbusy, issue, nopc, swn, perr;
  logic [23:0] fword;
  logic [1:0]  cyc;
  decoded_s    dec;
  issue_rec_s  recs[$];
  int          n_nop, n_swn, n_mismatch, checks_done;
  always #5 mclk_i = ~mclk_i;
  instruction_word_decoder i_dut (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .clk_en_i(en), .fetch_valid_i(fvalid),
    .fetch_word_i(fword), .cond_true_i(cond), .pc_write_i(pcw), .fetch_ready_o(fready),
    .issue_o(issue), .decoded_o(dec), .exec_cycles_o(cyc), .nop_cycle_o(nopc),
    .second_word_next_o(swn), .pair_error_o(perr));
  program_fetch_model i_fetch (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .clk_en_i(en), .fetch_ready_i(fready),
    .go_i(go), .gap_i(gap), .len_i(plen), .prog_i(prog), .fetch_valid_o(fvalid),
    .fetch_word_o(fword), .cond_true_o(cond), .pc_write_o(pcw), .busy_o(mbusy));
  // frozen cycles are not recorded: outputs merely hold then
  always @(posedge mclk_i) begin
    if (!sys_rst_i && en) begin
      if (issue) recs.push_back({dec, cyc, perr});
      if (nopc) n_nop++;
      if (swn) n_swn++;
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic tally_and_finish();
    if (n_mismatch == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish
  task automatic run(input int len, input logic gp, input logic fr);
    int k;
    recs.delete();
    n_nop = 0;
    n_swn = 0;
    @(posedge mclk_i);
    plen <= len[4:0];
    gap  <= gp;
    go   <= 1'b1;
    @(posedge mclk_i);
    go <= 1'b0;
    if (fr) begin
      repeat (2) @(posedge mclk_i);
      en <= 1'b0;
      repeat (3) @(posedge mclk_i);
      en <= 1'b1;
    end
    for (k = 0; k < 300; k++) begin
      @(negedge mclk_i);
      if (!mbusy) break;
    end
    if (k == 300) begin
      n_mismatch++;
      tally_and_finish();
    end
    repeat (6) @(posedge mclk_i);
  endtask : run
  task automatic s_cycles();
    logic [25:0] cp [14] = '{26'h0001234, 26'h0010000, 26'h0030000, 26'h0050000,
      26'h0060000, 26'h0070000, 26'h00B0000, 26'h00C0000, 26'h05F0000, 26'h0400000,
      26'h1400000, 26'h2090000, 26'h0090000, 26'h1000000};
    logic [1:0]  ce [14] = '{2'h1, 2'h2, 2'h2, 2'h2, 2'h3, 2'h3, 2'h2, 2'h2, 2'h2,
      2'h1, 2'h2, 2'h2, 2'h1, 2'h1};
    for (int i = 0; i < 14; i++) prog[i] <= cp[i];
    run(14, 1'b0, 1'b0);
    check(recs.size(), 14);
    for (int i = 0; i < 14; i++) begin
      check(recs[i].d.opcode, cp[i][23:16]);
      check(recs[i].cyc, ce[i]);
    end
    check(recs[0].d.is_nop, 1);
    check(n_nop, 12);
  endtask : s_cycles
  task automatic s_pair();
    logic [25:0] w [8] = '{26'h0021234, 26'h0005A7F, 26'h0048888, 26'h0000011,
      26'h008FFFF, 26'h000007F, 26'h0020000, 26'h0010000};
    for (int i = 0; i < 8; i++) prog[i] <= w[i];
    run(8, 1'b1, 1'b1);
    check(recs.size(), 4);
    for (int j = 0; j < 3; j++) begin
      check(recs[j].d.two_word, 1);
      check(recs[j].cyc, 2);
      check(recs[j].d.target, {w[2*j+1][6:0], w[2*j][15:0]});
      check(recs[j].d.literal, w[2*j+1][15:0]);
    end
    check({recs[3].d.is_nop, recs[3].perr}, 2'h3);
    check(n_swn, 8);
  endtask : s_pair
  task automatic s_skip();
    logic [25:0] w [9] = '{26'h20A0000, 26'h0400000, 26'h0410000, 26'h20A0000,
      26'h0020000, 26'h0000001, 26'h0420000, 26'h00A0000, 26'h0430000};
    logic [7:0]  op [6] = '{8'h0A, 8'h41, 8'h0A, 8'h42, 8'h0A, 8'h43};
    for (int i = 0; i < 9; i++) prog[i] <= w[i];
    run(9, 1'b0, 1'b0);
    check(recs.size(), 6);
    for (int i = 0; i < 6; i++) check(recs[i].d.opcode, op[i]);
    check(n_nop, 3);
  endtask : s_skip
  task automatic s_fields();
    logic [23:0] w [7] = '{24'h41A5C3, 24'h502ABC, 24'h80B800, 24'h213456,
      24'hA0F2D5, 24'hC05A50, 24'h050000};
    category_e   fc [7] = '{CAT_WORD_BYTE, CAT_WORD_BYTE, CAT_BIT, CAT_LITERAL,
      CAT_DSP, CAT_DSP, CAT_CONTROL};
    for (int i = 0; i < 7; i++) prog[i] <= {2'b00, w[i]};
    run(7, 1'b0, 1'b0);
    for (int i = 0; i < 7; i++) check(recs[i].d.category, fc[i]);
    check(recs[0].d.byte_mode, 1);
    check(recs[0].d.base_reg_operand, w[0][`IWD_F_BASE]);
    check({recs[0].d.dst_mode, recs[0].d.dest_reg_operand, recs[0].d.src_mode,
      recs[0].d.source_reg_operand}, w[0][11:0]);
    check({recs[1].d.file_form, recs[1].d.file_to_file, recs[1].d.file_addr},
      {1'b1, w[1][`IWD_F_FILE_SEL], w[1][`IWD_F_FILE]});
    check({recs[2].d.bit_indirect, recs[2].d.base_reg_operand}, 5'h1B);
    check({recs[3].d.base_reg_operand, recs[3].d.dest_reg_operand},
      {2{w[3][`IWD_F_BASE]}});
    check({recs[4].d.multiply_accumulate, recs[4].d.acc_b, recs[4].d.wx,
      recs[4].d.wy, recs[4].d.x_op, recs[4].d.y_op, recs[4].d.x_dst,
      recs[4].d.y_dst, recs[4].d.awb},
      {1'b1, w[4][15:0]});
    check({recs[5].d.multiply_accumulate, recs[5].d.shift_from_reg, recs[5].d.shift_amt},
      {1'b0, w[5][`IWD_F_SH_REG], w[5][`IWD_F_SH_LIT]});
  endtask : s_fields
  initial begin
    for (int i = 0; i < 16; i++) prog[i] = '0;
    repeat (16) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    s_cycles();
    s_pair();
    s_skip();
    s_fields();
    tally_and_finish();
  end
endmodule : instruction_word_decoder_tb

/* sim/program_fetch_model.sv */
// program memory fetch path model: plays a short program into the decoder
`timescale 1ns/1ps
module program_fetch_model (
  input  wire logic        mclk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        clk_en_i,
  input  wire logic        fetch_ready_i,
  input  wire logic        go_i,
  input  wire logic        gap_i,
  input  wire logic [4:0]  len_i,
  input  wire logic [25:0] prog_i [16],
  output logic             fetch_valid_o,
  output logic [23:0]      fetch_word_o,
  output logic             cond_true_o,
  output logic             pc_write_o,
  output logic             busy_o
);
  logic [4:0]  idx;
  logic        hole;
  logic [23:0] last;
  assign fetch_valid_o = busy_o && !hole;
  // idle bus shows the inverse of the last word so stale data never matches
  assign fetch_word_o  = fetch_valid_o ? prog_i[idx[3:0]][23:0] : ~last;
  assign cond_true_o   = fetch_valid_o && prog_i[idx[3:0]][25];
  assign pc_write_o    = fetch_valid_o && prog_i[idx[3:0]][24];
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      idx    <= '0;
      hole   <= 1'b0;
      busy_o <= 1'b0;
      last   <= '0;
    end else if (go_i) begin
      idx    <= '0;
      hole   <= 1'b0;
      busy_o <= 1'b1;
    end else if (busy_o && clk_en_i) begin
      // a gap after each word plays a slow memory
      hole <= fetch_valid_o && fetch_ready_i && gap_i;
      if (fetch_valid_o && fetch_ready_i) begin
        idx  <= idx + 5'h01;
        last <= fetch_word_o;
        if (idx + 5'h01 == len_i) begin
          busy_o <= 1'b0;
        end
      end
    end
  end
endmodule : program_fetch_model
